// ---- shc_cmd_if.sv ----
// Command interpreter of the sensor front end: frame decode, status and
// response bytes, measurement requests and redundant memory housekeeping.
// Assumes a serial slave (I2C or SPI) outside that delivers bytes and
// frame boundaries synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
`include "shc_consts.svh"

module shc_cmd_if
    import shc_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_end,
    input  wire logic        tx_start,
    input  wire logic        tx_next,
    output logic      [7:0]  tx_data,
    input  wire logic        test_mode,
    input  wire logic        dsp_saturated,
    output logic             meas_req,
    output logic      [2:0]  meas_type,
    output logic      [15:0] meas_cfg,
    output logic             meas_raw,
    input  wire logic        meas_done,
    input  wire logic [15:0] meas_result,
    output logic             cmd_mode,
    output logic             busy,
    output logic             mem_error,
    output logic      [1:0]  customer_page_index,
    output logic      [23:0] corr_flags
);

    shc_main_t   s_reg;
    shc_main_t   s_next;
    logic        mem_rd;
    logic        mem_wr;
    logic [15:0] mem_data;
    logic        mem_corr;
    logic [7:0]  status;
    logic [7:0]  cmd;
    logic [15:0] arg;

    ////////////////////////////////////////////////////////////////////////
    // Memory

    shc_nvm u_nvm (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .page    (s_reg.page),
        .addr    (s_reg.idx),
        .rd_en   (mem_rd),
        .wr_en   (mem_wr),
        .wr_data (s_reg.sum),
        .rd_data (mem_data),
        .rd_corr (mem_corr)
    );

    assign mem_rd = s_reg.st == SHC_RD;
    assign mem_wr = s_reg.st == SHC_WR;

    ////////////////////////////////////////////////////////////////////////
    // Status byte and frame fields

    always_comb begin
        status                    = 8'h00;
        status[`SHC_ST_POWERED]   = 1'b1;
        status[`SHC_ST_BUSY]      = s_reg.busy;
        status[`SHC_ST_TEST]      = test_mode;
        status[`SHC_ST_CMD]       = s_reg.cmd_mode;
        status[`SHC_ST_MEMERR]    = s_reg.mem_err;
        status[`SHC_ST_SAT]       = dsp_saturated;
    end

    assign cmd = s_reg.b0;
    // Bytes missing from a short frame read as zero, not as stale bytes
    assign arg = {s_reg.rx_cnt > 2'd1 ? s_reg.b1 : 8'h00,
                  s_reg.rx_cnt > 2'd2 ? s_reg.b2 : 8'h00};

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        s_next          = s_reg;
        s_next.meas_req = 1'b0;

        // Byte collection; extra bytes beyond three are dropped
        if (rx_valid && s_reg.rx_cnt < `SHC_CMD_BYTES) begin
            case (s_reg.rx_cnt)
                2'd0:    s_next.b0 = rx_data;
                2'd1:    s_next.b1 = rx_data;
                default: s_next.b2 = rx_data;
            endcase
            s_next.rx_cnt = s_reg.rx_cnt + 2'd1;
        end

        // Response bytes: status, result high, result low, then zero
        if (tx_start) begin
            s_next.tx_idx  = 3'd0;
            s_next.tx_data = status;
        end else if (tx_next) begin
            // Index stops at its top so a long read keeps returning zero
            if (s_reg.tx_idx != 3'd7) begin
                s_next.tx_idx = s_reg.tx_idx + 3'd1;
            end
            case (s_reg.tx_idx)
                3'd0:    s_next.tx_data = s_reg.result[15:8];
                3'd1:    s_next.tx_data = s_reg.result[7:0];
                default: s_next.tx_data = 8'h00;
            endcase
        end

        case (s_reg.st)
            SHC_IDLE: begin
                if (rx_end && s_reg.rx_cnt != 2'd0) begin
                    s_next.rx_cnt = 2'd0;
                    if (!rx_valid) begin
                        s_next.b1 = s_reg.rx_cnt > 2'd1 ? s_reg.b1 : 8'h00;
                        s_next.b2 = s_reg.rx_cnt > 2'd2 ? s_reg.b2 : 8'h00;
                    end
                    if (cmd == `SHC_CMD_ENTER) begin
                        s_next.cmd_mode = 1'b1;
                    end else if (cmd == `SHC_CMD_EXIT) begin
                        s_next.cmd_mode = 1'b0;
                    end else if (cmd[7:4] == `SHC_RAW_NIBBLE
                                 && !cmd[3]) begin
                        s_next.busy      = 1'b1;
                        s_next.meas_type = cmd[2:0];
                        s_next.meas_raw  = 1'b1;
                        if (cmd[0]) begin
                            // Configuration lives only in meas_cfg
                            s_next.meas_cfg = arg;
                            s_next.meas_req = 1'b1;
                            s_next.st       = SHC_MEAS;
                        end else if (!cmd[2]) begin
                            s_next.op  = SHC_OP_CFG;
                            s_next.idx = `SHC_BRIDGE_ADDR;
                            s_next.st  = SHC_RD;
                        end else begin
                            s_next.meas_cfg = `SHC_TEMP_CFG;
                            s_next.meas_req = 1'b1;
                            s_next.st       = SHC_MEAS;
                        end
                    end else if (cmd == `SHC_CMD_NORMAL) begin
                        s_next.busy      = 1'b1;
                        s_next.meas_type = 3'd0;
                        s_next.meas_cfg  = 16'h0000;
                        s_next.meas_raw  = 1'b0;
                        s_next.meas_req  = 1'b1;
                        s_next.st        = SHC_MEAS;
                    end else if (cmd[7:5] == `SHC_MRD_TOP
                                 && cmd[4:0] < `SHC_WORDS) begin
                        s_next.busy = 1'b1;
                        s_next.op   = SHC_OP_MRD;
                        s_next.idx  = cmd[4:0];
                        s_next.st   = SHC_RD;
                    end else if (s_reg.cmd_mode) begin
                        if (cmd[7:5] == `SHC_MWR_TOP
                            && cmd[4:0] < `SHC_WORDS) begin
                            s_next.busy = 1'b1;
                            s_next.idx  = cmd[4:0];
                            s_next.sum  = arg;
                            s_next.st   = SHC_WR;
                        end else if (cmd == `SHC_CMD_CHECKSUM) begin
                            s_next.busy = 1'b1;
                            s_next.op   = SHC_OP_SUM;
                            s_next.idx  = 5'd0;
                            s_next.sum  = 16'h0000;
                            s_next.st   = SHC_RD;
                        end else if (cmd == `SHC_CMD_PAGE_INC
                                     && s_reg.page != `SHC_PAGE_MAX) begin
                            s_next.page = s_reg.page + 2'd1;
                        end
                    end
                end
            end
            SHC_RD: begin
                s_next.st = SHC_RDW;
            end
            SHC_RDW: begin
                s_next.corr[s_reg.idx] = s_reg.corr[s_reg.idx]
                                         | mem_corr;
                s_next.st = SHC_RD;
                case (s_reg.op)
                    SHC_OP_BOOT: begin
                        if (s_reg.idx == `SHC_SIG_ADDR) begin
                            s_next.mem_err = s_reg.sum != mem_data;
                            s_next.busy    = 1'b0;
                            s_next.st      = SHC_IDLE;
                        end else begin
                            s_next.sum = s_reg.sum + mem_data;
                            s_next.idx = s_reg.idx + 5'd1;
                        end
                    end
                    SHC_OP_SUM: begin
                        s_next.sum = s_reg.sum + mem_data;
                        if (s_reg.idx == `SHC_SIG_ADDR - 5'd1) begin
                            s_next.st = SHC_WR;
                        end
                        s_next.idx = s_reg.idx + 5'd1;
                    end
                    SHC_OP_MRD: begin
                        s_next.result = mem_data;
                        s_next.busy   = 1'b0;
                        s_next.st     = SHC_IDLE;
                    end
                    default: begin
                        s_next.meas_cfg = mem_data;
                        s_next.meas_req = 1'b1;
                        s_next.st       = SHC_MEAS;
                    end
                endcase
            end
            SHC_WR: begin
                s_next.busy = 1'b0;
                s_next.st   = SHC_IDLE;
            end
            SHC_MEAS: begin
                if (meas_done) begin
                    s_next.result = meas_result;
                    s_next.busy   = 1'b0;
                    s_next.st     = SHC_IDLE;
                end
            end
            default: begin
                s_next.st = SHC_IDLE;
            end
        endcase

        // A finished frame while busy is dropped
        if (rx_end && s_reg.st != SHC_IDLE) begin
            s_next.rx_cnt = 2'd0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; power-up integrity scan starts from reset

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_reg      <= '0;
            s_reg.st   <= SHC_RD;
            s_reg.op   <= SHC_OP_BOOT;
            s_reg.busy <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign tx_data             = s_reg.tx_data;
    assign meas_req            = s_reg.meas_req;
    assign meas_type           = s_reg.meas_type;
    assign meas_cfg            = s_reg.meas_cfg;
    assign meas_raw            = s_reg.meas_raw;
    assign cmd_mode            = s_reg.cmd_mode;
    assign busy                = s_reg.busy;
    assign mem_error           = s_reg.mem_err;
    assign customer_page_index = s_reg.page;
    assign corr_flags          = s_reg.corr;

endmodule
`default_nettype wire

// ---- shc_consts.svh ----
// Constants of the sensor host command interface: codes, status bits, sizes.
// Assumes inclusion by the design modules only, not by shc_pkg.sv.
`ifndef SHC_CONSTS_SVH
`define SHC_CONSTS_SVH

`define SHC_CMD_ENTER      8'ha9
`define SHC_CMD_EXIT       8'ha8
`define SHC_RAW_NIBBLE     4'ha
`define SHC_CMD_NORMAL     8'hac
`define SHC_CMD_CHECKSUM   8'h90
`define SHC_CMD_PAGE_INC   8'h5e
`define SHC_MRD_TOP        3'b000
`define SHC_MWR_TOP        3'b010

`define SHC_WORDS          5'd24
`define SHC_SIG_ADDR       5'd23
`define SHC_BRIDGE_ADDR    5'd01
`define SHC_PAGE_MAX       2'd3
`define SHC_MEM_DEPTH      96
`define SHC_TEMP_CFG       16'h0000
`define SHC_RESP_BYTES     3'd5
`define SHC_CMD_BYTES      2'd3

`define SHC_ST_POWERED     6
`define SHC_ST_BUSY        5
`define SHC_ST_TEST        4
`define SHC_ST_CMD         3
`define SHC_ST_MEMERR      2
`define SHC_ST_SAT         0

`endif

// ---- shc_pkg.sv ----
// Types of the sensor host command interface.
// Assumes shc_consts.svh is on the include path.
package shc_pkg;

    typedef enum logic [2:0] {
        SHC_IDLE,
        SHC_RD,
        SHC_RDW,
        SHC_WR,
        SHC_MEAS
    } shc_state_t;

    typedef enum logic [1:0] {
        SHC_OP_BOOT,
        SHC_OP_SUM,
        SHC_OP_MRD,
        SHC_OP_CFG
    } shc_op_t;

    typedef struct packed {
        shc_state_t  st;
        shc_op_t     op;
        logic        cmd_mode;
        logic        busy;
        logic        mem_err;
        logic [1:0]  page;
        logic [1:0]  rx_cnt;
        logic [7:0]  b0;
        logic [7:0]  b1;
        logic [7:0]  b2;
        logic [4:0]  idx;
        logic [15:0] sum;
        logic [15:0] result;
        logic [23:0] corr;
        logic [2:0]  tx_idx;
        logic [7:0]  tx_data;
        logic        meas_req;
        logic [2:0]  meas_type;
        logic [15:0] meas_cfg;
        logic        meas_raw;
    } shc_main_t;

    typedef struct packed {
        logic [95:0][31:0] mem;
        logic [15:0]       rd_data;
        logic              rd_corr;
    } shc_mem_t;

endpackage

// ---- shc_nvm.sv ----
// Redundant user memory: four pages of 24 words, each word kept twice.
// Assumes one write or one read per cycle from the command interpreter.
`timescale 1ns/1ps
`default_nettype none
`include "shc_consts.svh"

module shc_nvm
    import shc_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic [1:0]  page,
    input  wire logic [4:0]  addr,
    input  wire logic        rd_en,
    input  wire logic        wr_en,
    input  wire logic [15:0] wr_data,
    output logic      [15:0] rd_data,
    output logic             rd_corr
);

    shc_mem_t   s_reg;
    shc_mem_t   s_next;
    logic [6:0] loc;

    assign loc = 7'(page * 7'd24) + {2'b00, addr};

    always_comb begin
        s_next = s_reg;
        if (wr_en) begin
            s_next.mem[loc] = {wr_data, wr_data};
        end
        if (rd_en) begin
            // Primary copy is returned; mismatch raises the correction flag
            s_next.rd_data = s_reg.mem[loc][15:0];
            s_next.rd_corr = s_reg.mem[loc][31:16] != s_reg.mem[loc][15:0];
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign rd_data = s_reg.rd_data;
    assign rd_corr = s_reg.rd_corr;

endmodule
`default_nettype wire

// ---- shc_cmd_if_props.sv ----
// Port checks of the command interpreter.
// Assumes a bind onto shc_cmd_if; one clock, async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module shc_cmd_if_props
    import shc_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire logic        rx_valid,
    input wire logic [7:0]  rx_data,
    input wire logic        rx_end,
    input wire logic        tx_start,
    input wire logic [7:0]  tx_data,
    input wire logic        test_mode,
    input wire logic        dsp_saturated,
    input wire logic        meas_req,
    input wire logic        meas_raw,
    input wire logic [15:0] meas_cfg,
    input wire logic        meas_done,
    input wire logic        cmd_mode,
    input wire logic        busy,
    input wire logic        mem_error,
    input wire logic [1:0]  customer_page_index
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////////////
    sequence s_tail;
        rx_valid ##1 rx_valid ##1 rx_end && !busy;
    endsequence
    sequence s_raw_cfg;
        rx_valid && rx_data[7:4] == 4'ha && !rx_data[3] && rx_data[0]
            ##1 s_tail;
    endsequence
    sequence s_enter;
        rx_valid && rx_data == 8'ha9 ##1 s_tail;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    a_status_first: assert property (
        tx_start |=> tx_data[6] && tx_data[5] == $past(busy)
            && tx_data[3] == $past(cmd_mode) && tx_data[2] == $past(mem_error))
        else $error("status byte wrong after read start");
    a_status_flags: assert property (
        tx_start |=> tx_data[4] == $past(test_mode)
            && tx_data[0] == $past(dsp_saturated) && !tx_data[7])
        else $error("status test or saturation bit wrong");
    a_raw_cfg: assert property (
        s_raw_cfg |=> meas_req && meas_raw
            && meas_cfg == {$past(rx_data, 3), $past(rx_data, 2)})
        else $error("raw request lost its supplied configuration");
    a_enter_cmd: assert property (
        s_enter |=> cmd_mode)
        else $error("command state not entered");
    a_req_busy: assert property (
        meas_req |-> busy)
        else $error("measurement started without busy");
    a_req_pulse: assert property (
        meas_req |=> !meas_req)
        else $error("measurement request longer than one cycle");
    a_done_clears: assert property (
        busy && meas_done |=> !busy)
        else $error("busy held after measurement done");
    a_drop_busy: assert property (
        rx_end && busy && $past(busy, 3) |=> !meas_req)
        else $error("frame taken while busy");
    a_page_step: assert property (
        $changed(customer_page_index) |-> $past(cmd_mode)
            && customer_page_index == $past(customer_page_index) + 2'd1)
        else $error("page index moved wrongly");
    a_page_hold: assert property (
        customer_page_index == 2'd3 |=> customer_page_index == 2'd3)
        else $error("page index passed the last page");
endmodule
`default_nettype wire

// ---- shc_meas_model.sv ----
// Measurement engine model: answers each request after a delay.
// Assumes request is a one-cycle pulse; type and raw flag hold until the next command.
`timescale 1ns/1ps
`default_nettype none
module shc_meas_model
    import shc_pkg::*;
#(
    parameter int DELAY = 20
)
(
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire logic        meas_req,
    input wire logic [2:0]  meas_type,
    input wire logic        meas_raw,
    output logic            meas_done,
    output logic     [15:0] meas_result
);
    int cnt;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= 0;
            meas_done <= 1'b0;
            meas_result <= 16'h0000;
        end else begin
            meas_done <= 1'b0;
            if (meas_req) begin
                cnt <= DELAY;
            end else if (cnt == 1) begin
                cnt <= 0;
                meas_done <= 1'b1;
                // Raw counts carry the type, corrected ones a fixed code
                meas_result <= meas_raw ? {5'h00, meas_type, 8'h5a}
                                        : 16'hfe01;
            end else begin
                if (cnt > 1) cnt <= cnt - 1;
                // Result is only valid with done
                if (meas_done) meas_result <= ~meas_result;
            end
        end
    end
endmodule
`default_nettype wire

// ---- shc_cmd_if_tb.sv ----
// Testbench of the command interpreter: host frames and response reads.
// Assumes shc_cmd_if, shc_meas_model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module shc_cmd_if_tb;
    import shc_pkg::*;
    logic        sys_clk = 1'b0;
    logic        reset_n, rx_valid, rx_end, tx_start, tx_next;
    logic        test_mode, dsp_saturated, meas_req, meas_raw, meas_done;
    logic        cmd_mode, busy, mem_error;
    logic [7:0]  rx_data, tx_data;
    logic [2:0]  meas_type;
    logic [15:0] meas_cfg, meas_result;
    logic [1:0]  customer_page_index;
    logic [23:0] corr_flags;
    int          bad_count = 0;
    int          samples_checked = 0;

    shc_cmd_if dut (.*);
    shc_meas_model #(.DELAY(20)) far_end (.*);
    always #2.5 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask
    task automatic send(input logic [7:0] c, input logic [15:0] arg);
        tick();
        rx_valid = 1'b1;
        rx_data = c;
        tick();
        rx_data = arg[15:8];
        tick();
        rx_data = arg[7:0];
        tick();
        rx_valid = 1'b0;
        rx_end = 1'b1;
        tick();
        rx_end = 1'b0;
    endtask
    task automatic fetch(input logic [7:0] st, input logic [15:0] res);
        logic [7:0] e;
        tick();
        tx_start = 1'b1;
        tick();
        tx_start = 1'b0;
        tx_next = 1'b1;
        chk("status", {8'h00, st}, {8'h00, tx_data});
        for (int i = 1; i < 5; i++) begin
            tick();
            e = i == 1 ? res[15:8] : (i == 2 ? res[7:0] : 8'h00);
            chk("response byte", {8'h00, e}, {8'h00, tx_data});
        end
        tx_next = 1'b0;
    endtask
    task automatic wait_idle();
        for (int n = 0; n < 500 && busy !== 1'b0; n++) tick();
        chk("busy", 16'h0000, {15'h0000, busy});
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {reset_n, rx_valid, rx_end, tx_start, tx_next} = 5'h00;
        {test_mode, dsp_saturated, rx_data} = 10'h000;
        repeat (10) @(posedge sys_clk);
        #1 reset_n = 1'b1;
        wait_idle();
        chk("mem error", 16'h0000, {15'h0000, mem_error});
        fetch(8'h40, 16'h0000);
        send(8'h5e, 16'h0000);
        chk("page", 16'h0000, {14'h0000, customer_page_index});
        send(8'ha9, 16'h0000);
        chk("cmd mode", 16'h0001, {15'h0000, cmd_mode});
        test_mode = 1'b1;
        dsp_saturated = 1'b1;
        fetch(8'h59, 16'h0000);
        test_mode = 1'b0;
        dsp_saturated = 1'b0;
        send(8'h41, 16'habcd);
        wait_idle();
        send(8'h56, 16'h1111);
        wait_idle();
        send(8'h01, 16'h0000);
        wait_idle();
        fetch(8'h48, 16'habcd);
        send(8'h90, 16'h0000);
        wait_idle();
        send(8'h17, 16'h0000);
        wait_idle();
        fetch(8'h48, 16'hbcde);
        for (int t = 0; t < 8; t++) begin
            send(8'ha0 | t[7:0], 16'h1234);
            for (int n = 0; n < 4 && meas_req !== 1'b1; n++) tick();
            chk("request", 16'h0001, {15'h0000, meas_req});
            chk("type", 16'(t), {13'h0000, meas_type});
            chk("cfg", t[0] ? 16'h1234 : (t < 4 ? 16'habcd : 16'h0000),
                meas_cfg);
            wait_idle();
            fetch(8'h48, {5'h00, t[2:0], 8'h5a});
        end
        send(8'hac, 16'h0000);
        chk("raw", 16'h0000, {15'h0000, meas_raw});
        wait_idle();
        fetch(8'h48, 16'hfe01);
        send(8'ha3, 16'h0248);
        chk("cfg", 16'h0248, meas_cfg);
        send(8'ha1, 16'h5555);
        chk("cfg", 16'h0248, meas_cfg);
        wait_idle();
        fetch(8'h48, 16'h035a);
        for (int k = 1; k < 5; k++) begin
            send(8'h5e, 16'h0000);
            chk("page", k > 3 ? 16'h0003 : 16'(k),
                {14'h0000, customer_page_index});
        end
        send(8'h01, 16'h0000);
        wait_idle();
        fetch(8'h48, 16'h0000);
        send(8'ha8, 16'h0000);
        chk("cmd mode", 16'h0000, {15'h0000, cmd_mode});
        chk("corr", 16'h0000, corr_flags[15:0] | {8'h00, corr_flags[23:16]});
        reset_n = 1'b0;
        tick();
        reset_n = 1'b1;
        chk("page", 16'h0000, {14'h0000, customer_page_index});
        wait_idle();
        chk("mem error", 16'h0000, {15'h0000, mem_error});
        summarize();
    end
    initial begin
        #60us;
        bad_count++;
        $display("[FAIL] watchdog expected done seen hang");
        summarize();
    end
endmodule
bind shc_cmd_if shc_cmd_if_props u_props (.*);
`default_nettype wire
